// ### shared/activation_regs.svh
// Register offsets, field positions, reset values and timing counts
// for the channel activation matrix.
// Assumes a 100 MHz bus clock; included by the package, the top module, the power stage bank and the bench.
`ifndef ACTIVATION_REGS_SVH
`define ACTIVATION_REGS_SVH

// ****************************************************************
// Channel count and pin population
// ****************************************************************
`define NUM_CH              4
`define CH_HAS_PIN          4'hF

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ADDR_SWITCH         8'h00
`define ADDR_LOAD_TYPE      8'h04
`define ADDR_HW_CONTROL     8'h08
`define ADDR_BANK_SWITCH    8'h0C
`define ADDR_DIAG_CONTROL   8'h10
`define ADDR_STATUS         8'h14

// ****************************************************************
// Field positions
// ****************************************************************
`define HW_CTRL_COMBINE_BIT 0
`define HW_CTRL_RESET_BIT   1
`define BANK_SELECT_BIT     0
`define STAT_STANDBY_BIT    0
`define STAT_LIMP_BIT       1
`define STAT_OUT_LSB        4

// ****************************************************************
// Reset values
// ****************************************************************
`define SWITCH_RESET        4'h0
`define LOAD_TYPE_RESET     4'h0
`define COMBINE_RESET       1'h0
`define BANK_SELECT_RESET   1'h0
`define SENSE_RESET         3'h7
`define SENSE_STANDBY       3'h7

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS       10
`define FALLBACK_ACK_TIME_NS 200000
`define FALLBACK_ACK_CYCLES  (`FALLBACK_ACK_TIME_NS / `CLK_PERIOD_NS)

`endif

// ### shared/activation_pkg.sv
// Types used by the channel activation matrix alone; its power stage bank uses none of them.
// Assumes activation_regs.svh provides the channel count.
`include "activation_regs.svh"

package activation_pkg;

   // ****************************************************************
   // Fallback qualification states, Gray along normal -> qualify -> limp
   // ****************************************************************
   typedef enum logic [1:0] {
      ST_NORMAL  = 2'h0,
      ST_QUALIFY = 2'h1,
      ST_LIMP    = 2'h3
   } limp_state_t;

   // ****************************************************************
   // Decoded register selection
   // ****************************************************************
   typedef enum logic [2:0] {
      SEL_SWITCH = 3'h0,
      SEL_LOAD   = 3'h1,
      SEL_HW_CTRL = 3'h2,
      SEL_BANK   = 3'h3,
      SEL_DIAG   = 3'h4,
      SEL_STATUS = 3'h5,
      SEL_NONE   = 3'h6
   } reg_sel_t;

   // ****************************************************************
   // Writable configuration, carried as one word
   // ****************************************************************
   typedef struct packed {
      logic [`NUM_CH-1:0] switch_bits;
      logic [`NUM_CH-1:0] load_type_bits;
      logic               input_combine_select;
      logic               bank_switch_select;
      logic [2:0]         sense_select_field;
   } cfg_t;

endpackage

// ### src/power_stage_bank.sv
// Per-channel output stage: registers each channel's drive and load profile.
// Assumes demand is already combined and gated by the top module.
`timescale 1ns/1ps
`include "activation_regs.svh"

module power_stage_bank #(
   parameter int NUM_CH = `NUM_CH
) (
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic [NUM_CH-1:0] demand,
   input  wire logic [NUM_CH-1:0] load_type,
   input  wire logic [NUM_CH-1:0] thermal_fault,
   output logic      [NUM_CH-1:0] power_stage_pin,
   output logic      [NUM_CH-1:0] led_profile
);

   // ****************************************************************
   // One independent stage per channel
   // ****************************************************************
   for (genvar i = 0; i < NUM_CH; i++) begin : g_stage
      logic next_pin;
      logic next_led;

      // Each channel watches only its own thermal flag, so it restarts alone
      always_comb begin
         next_pin = demand[i] & ~thermal_fault[i];
         next_led = load_type[i];
      end

      // Output flops
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            power_stage_pin[i] <= 1'h0;
            led_profile[i]     <= 1'h0;
         end else begin
            power_stage_pin[i] <= next_pin;
            led_profile[i]     <= next_led;
         end
      end
   end

endmodule // power_stage_bank

// ### src/channel_activation_matrix.sv
// Channel activation matrix with an AHB-Lite register slave.
// Assumes pins are synchronous to hclk and a single-master AHB-Lite bus.
//
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "activation_regs.svh"

module channel_activation_matrix #(
   parameter logic [`NUM_CH-1:0] HAS_PIN             = `CH_HAS_PIN,
   parameter int                 FALLBACK_ACK_CYCLES = `FALLBACK_ACK_CYCLES
) (
   input  wire logic               hclk,
   input  wire logic               hresetn,
   input  wire logic               hsel,
   input  wire logic [31:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [31:0]        hwdata,
   input  wire logic               hready,
   output logic                    hreadyout,
   output logic                    hresp,
   output logic      [31:0]        hrdata,
   input  wire logic [`NUM_CH-1:0] direct_drive_pin,
   input  wire logic               fallback_drive_pin,
   input  wire logic [`NUM_CH-1:0] thermal_fault,
   output logic      [`NUM_CH-1:0] power_stage_pin,
   output logic      [`NUM_CH-1:0] led_profile,
   output logic                    standby_flag,
   output logic                    limp_home
);

   localparam int CNT_W = $clog2(FALLBACK_ACK_CYCLES + 1);

   // ****************************************************************
   // Helpers
   // ****************************************************************

   // Address decode shared by the read and the write path
   function automatic activation_pkg::reg_sel_t reg_index(input logic [7:0] a);
      unique case (a)
         `ADDR_SWITCH:       reg_index = activation_pkg::SEL_SWITCH;
         `ADDR_LOAD_TYPE:    reg_index = activation_pkg::SEL_LOAD;
         `ADDR_HW_CONTROL:   reg_index = activation_pkg::SEL_HW_CTRL;
         `ADDR_BANK_SWITCH:  reg_index = activation_pkg::SEL_BANK;
         `ADDR_DIAG_CONTROL: reg_index = activation_pkg::SEL_DIAG;
         `ADDR_STATUS:       reg_index = activation_pkg::SEL_STATUS;
         default:            reg_index = activation_pkg::SEL_NONE;
      endcase
   endfunction

   // Default configuration, used at reset, on the reset command and in limp home
   function automatic activation_pkg::cfg_t cfg_default();
      activation_pkg::cfg_t c;
      c.switch_bits          = `SWITCH_RESET;
      c.load_type_bits       = `LOAD_TYPE_RESET;
      c.input_combine_select = `COMBINE_RESET;
      c.bank_switch_select   = `BANK_SELECT_RESET;
      c.sense_select_field   = `SENSE_RESET;
      return c;
   endfunction

   // ****************************************************************
   // State
   // ****************************************************************
   activation_pkg::cfg_t        cfg;
   activation_pkg::cfg_t        next_cfg;
   activation_pkg::limp_state_t limp_state;
   activation_pkg::limp_state_t next_limp_state;
   logic [CNT_W-1:0]            ack_cnt;
   logic [CNT_W-1:0]            next_ack_cnt;
   logic                        wr_pend;
   logic                        next_wr_pend;
   logic [7:0]                  wr_addr;
   logic [7:0]                  next_wr_addr;
   logic [31:0]                 next_hrdata;
   logic                        next_standby_flag;
   logic                        next_limp_home;

   logic                        addr_ok;
   logic                        in_limp;
   logic                        standby_now;
   logic                        or_mode;
   logic [`NUM_CH-1:0]          pins;
   logic [`NUM_CH-1:0]          or_term;
   logic [`NUM_CH-1:0]          and_term;
   logic [`NUM_CH-1:0]          demand;
   logic [`NUM_CH-1:0]          wdata_lo;

   // ****************************************************************
   // Bus decode and channel combination
   // ****************************************************************

   // A transfer is taken only when the bus is ready and the slot is active
   assign addr_ok     = hsel & hready & htrans[1];
   assign in_limp     = (limp_state == activation_pkg::ST_LIMP);
   assign wdata_lo    = hwdata[`NUM_CH-1:0];
   // Limp home wakes the device even though the sense field reads default
   assign standby_now = (cfg.sense_select_field == `SENSE_STANDBY) & ~in_limp;
   // Pinless positions never contribute, so a missing pin reads as low
   assign pins        = direct_drive_pin & HAS_PIN;
   assign or_mode     = ~cfg.input_combine_select | in_limp;
   assign or_term     = cfg.switch_bits | pins;
   // The pin term is absent on channels without a pin, so the bit alone decides
   assign and_term    = cfg.switch_bits & (pins | ~HAS_PIN);

   // Stand-by wins over every input; otherwise the selected combination
   always_comb begin
      if (standby_now) begin
         demand = '0;
      end else if (or_mode) begin
         demand = or_term;
      end else begin
         demand = and_term;
      end
   end

   // ****************************************************************
   // Configuration registers
   // ****************************************************************

   // Writes land in the data phase; limp home holds everything at default
   always_comb begin
      next_cfg = cfg;
      if (in_limp) begin
         next_cfg = cfg_default();
      end else if (wr_pend) begin
         unique case (reg_index(wr_addr))
            activation_pkg::SEL_SWITCH: begin
               next_cfg.switch_bits = wdata_lo;
            end
            activation_pkg::SEL_LOAD: begin
               // Accepted whatever the channel state is, but only while bank switch select is clear
               if (!cfg.bank_switch_select) begin
                  next_cfg.load_type_bits = wdata_lo;
               end
            end
            activation_pkg::SEL_HW_CTRL: begin
               if (hwdata[`HW_CTRL_RESET_BIT]) begin
                  next_cfg = cfg_default();
               end else begin
                  next_cfg.input_combine_select = hwdata[`HW_CTRL_COMBINE_BIT];
               end
            end
            activation_pkg::SEL_BANK: begin
               next_cfg.bank_switch_select = hwdata[`BANK_SELECT_BIT];
            end
            activation_pkg::SEL_DIAG: begin
               next_cfg.sense_select_field = hwdata[2:0];
            end
            default: begin
               next_cfg = cfg;
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg <= cfg_default();
      end else begin
         cfg <= next_cfg;
      end
   end

   // ****************************************************************
   // Fallback pin qualification
   // ****************************************************************

   // A counter rather than a plain sync: short glitches must never reset registers
   always_comb begin
      next_limp_state = limp_state;
      next_ack_cnt    = ack_cnt;
      if (!fallback_drive_pin) begin
         next_limp_state = activation_pkg::ST_NORMAL;
         next_ack_cnt    = '0;
      end else begin
         unique case (limp_state)
            activation_pkg::ST_NORMAL: begin
               next_limp_state = activation_pkg::ST_QUALIFY;
               next_ack_cnt    = CNT_W'(1);
            end
            activation_pkg::ST_QUALIFY: begin
               if (ack_cnt >= CNT_W'(FALLBACK_ACK_CYCLES)) begin
                  next_limp_state = activation_pkg::ST_LIMP;
               end else begin
                  next_ack_cnt = ack_cnt + CNT_W'(1);
               end
            end
            activation_pkg::ST_LIMP: begin
               next_limp_state = activation_pkg::ST_LIMP;
            end
            default: begin
               next_limp_state = activation_pkg::ST_NORMAL;
               next_ack_cnt    = '0;
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         limp_state <= activation_pkg::ST_NORMAL;
         ack_cnt    <= '0;
      end else begin
         limp_state <= next_limp_state;
         ack_cnt    <= next_ack_cnt;
      end
   end

   // ****************************************************************
   // Bus slave: address capture, read data, status outputs
   // ****************************************************************

   // Read data is built in the address phase so the slave never waits;
   // a read issued while a write to the same register is still in its data
   // phase would see the old value, which a single-outstanding master avoids
   always_comb begin
      next_wr_pend      = addr_ok & hwrite & ~in_limp;
      next_wr_addr      = haddr[7:0];
      next_hrdata       = hrdata;
      next_standby_flag = standby_now;
      next_limp_home    = (next_limp_state == activation_pkg::ST_LIMP);
      if (addr_ok && !hwrite) begin
         next_hrdata = 32'h0000_0000;
         unique case (reg_index(haddr[7:0]))
            activation_pkg::SEL_SWITCH: begin
               if (!cfg.bank_switch_select) begin
                  next_hrdata[`NUM_CH-1:0] = cfg.switch_bits;
               end else if (!standby_now) begin
                  next_hrdata[`NUM_CH-1:0] = pins;
               end
            end
            activation_pkg::SEL_LOAD: begin
               if (!cfg.bank_switch_select) begin
                  next_hrdata[`NUM_CH-1:0] = cfg.load_type_bits;
               end
            end
            activation_pkg::SEL_HW_CTRL: begin
               next_hrdata[`HW_CTRL_COMBINE_BIT] = cfg.input_combine_select;
            end
            activation_pkg::SEL_BANK: begin
               next_hrdata[`BANK_SELECT_BIT] = cfg.bank_switch_select;
            end
            activation_pkg::SEL_DIAG: begin
               next_hrdata[2:0] = cfg.sense_select_field;
            end
            activation_pkg::SEL_STATUS: begin
               next_hrdata[`STAT_STANDBY_BIT] = standby_flag;
               next_hrdata[`STAT_LIMP_BIT]    = limp_home;
               next_hrdata[`STAT_OUT_LSB +: `NUM_CH] = power_stage_pin;
            end
            default: begin
               next_hrdata = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend      <= 1'h0;
         wr_addr      <= 8'h00;
         hrdata       <= 32'h0000_0000;
         hreadyout    <= 1'h1;
         hresp        <= 1'h0;
         standby_flag <= 1'h0;
         limp_home    <= 1'h0;
      end else begin
         wr_pend      <= next_wr_pend;
         wr_addr      <= next_wr_addr;
         hrdata       <= next_hrdata;
         hreadyout    <= 1'h1;
         hresp        <= 1'h0;
         standby_flag <= next_standby_flag;
         limp_home    <= next_limp_home;
      end
   end

   // ****************************************************************
   // Power stages
   // ****************************************************************
   power_stage_bank #(
      .NUM_CH          (`NUM_CH)
   ) u_stages (
      .hclk            (hclk),
      .hresetn         (hresetn),
      .demand          (demand),
      .load_type       (cfg.load_type_bits),
      .thermal_fault   (thermal_fault),
      .power_stage_pin (power_stage_pin),
      .led_profile     (led_profile)
   );

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_or_combine:
   assert property ((!standby_now && !in_limp && !cfg.input_combine_select)
                    |=> power_stage_pin == ($past(or_term) & ~$past(thermal_fault)))
      else $error("OR combination not applied to outputs");

   a_and_combine:
   assert property ((!standby_now && !in_limp && cfg.input_combine_select)
                    |=> power_stage_pin == ($past(and_term) & ~$past(thermal_fault)))
      else $error("AND combination not applied to outputs");

   a_limp_pins_only:
   assert property (in_limp ##1 in_limp
                    |=> power_stage_pin == ($past(pins) & ~$past(thermal_fault)))
      else $error("Limp home outputs do not follow the pins");

   a_standby_all_off:
   assert property (standby_now |=> (power_stage_pin == '0) && standby_flag)
      else $error("Stand-by left a channel on or the flag clear");

   a_readback_pins:
   assert property ((addr_ok && !hwrite && cfg.bank_switch_select && !standby_now
                     && reg_index(haddr[7:0]) == activation_pkg::SEL_SWITCH)
                    |=> hrdata[`NUM_CH-1:0] == $past(pins))
      else $error("Switch register read did not return pin levels");

   a_limp_defaults:
   assert property (in_limp |=> !cfg.input_combine_select && cfg.switch_bits == '0
                    && cfg.sense_select_field == `SENSE_RESET)
      else $error("Limp home did not restore defaults");

   a_limp_entry_time:
   assert property ($rose(in_limp) |-> $past(ack_cnt) == CNT_W'(FALLBACK_ACK_CYCLES)
                    && $past(fallback_drive_pin))
      else $error("Limp home entered before the acknowledgement time");

   a_glitch_ignored:
   assert property (!fallback_drive_pin |=> !in_limp && ack_cnt == '0)
      else $error("Low fallback pin did not drop qualification");

   a_load_any_state:
   assert property ((wr_pend && !in_limp && !cfg.bank_switch_select
                     && reg_index(wr_addr) == activation_pkg::SEL_LOAD)
                    |=> cfg.load_type_bits == $past(wdata_lo) ##1 led_profile == $past(wdata_lo, 2))
      else $error("Load-type write not applied");

   a_thermal_off:
   assert property (thermal_fault[0] && !thermal_fault[1] && demand[1]
                    |=> !power_stage_pin[0] && power_stage_pin[1])
      else $error("Thermal fault not confined to its own channel");

endmodule // channel_activation_matrix

// ### tb/host_model.sv
// Host model: the single AHB-Lite master that reaches the register slave.
// Assumes hready is the slave's hreadyout and one clock for the whole bus.
`timescale 1ns/1ps
module host_model (
   input  wire logic        hclk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic      [1:0]  htrans,
   output logic      [31:0] haddr,
   output logic             hwrite,
   output logic      [31:0] hwdata,
   output logic             hung
);
   // ****************************************************************
   // Bus cycles
   // ****************************************************************
   // Idle bus at time zero
   initial begin
      htrans = 2'h0;
      haddr  = 32'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      hung   = 1'b0;
   end
   // Bounded wait for hready at a rising edge; a stuck slave raises hung
   task automatic wait_ready();
      int n;
      n = 0;
      @(posedge hclk);
      while (hready !== 1'b1 && n < 64) begin
         @(posedge hclk);
         n++;
      end
      if (n == 64) hung <= 1'b1;
   endtask
   // Address phase is held until accepted, then the data phase follows
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q);
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= w;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
      q = hrdata;
   endtask
endmodule // host_model

// ### tb/channel_activation_matrix_tb.sv
// Self-checking bench for the channel activation matrix.
// Assumes the host model drives the bus; pins are driven here on hclk.
`timescale 1ns/1ps
`include "activation_regs.svh"
module channel_activation_matrix_tb;
   logic        hclk, hresetn, hwrite, hreadyout, hresp, hung, fb, standby_flag, limp_home;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [3:0]  pins, out, led, tf;
   int          errors, comparisons;
   // ****************************************************************
   // Design, host and clock
   // ****************************************************************
   // Short acknowledgement count keeps the limp home run brief
   channel_activation_matrix #(.HAS_PIN(4'hF), .FALLBACK_ACK_CYCLES(8))
      i_channel_activation_matrix (
      .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .direct_drive_pin(pins),
      .fallback_drive_pin(fb), .thermal_fault(tf), .power_stage_pin(out),
      .led_profile(led), .standby_flag(standby_flag), .limp_home(limp_home));
   host_model host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .htrans(htrans),
      .haddr(haddr), .hwrite(hwrite), .hwdata(hwdata), .hung(hung));
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   // A hung bus ends the run at once
   always @(posedge hung) begin
      errors++;
      report_and_stop();
   end
   // ****************************************************************
   // Helpers
   // ****************************************************************
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Let the edges land before looking
   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.xfer(a, 1'b1, d, q);
   endtask
   task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
      host.xfer(a, 1'b0, 32'h0, q);
      check(name, q, exp);
   endtask
   task automatic drive(input logic [3:0] p);
      @(posedge hclk);
      pins <= p;
   endtask
   task automatic report_and_stop();
      if (errors == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset();
      rd("switch", `ADDR_SWITCH, 32'h0);
      rd("load", `ADDR_LOAD_TYPE, 32'h0);
      rd("hw_ctrl", `ADDR_HW_CONTROL, 32'h0);
      rd("diag", `ADDR_DIAG_CONTROL, 32'h7);
      rd("status", `ADDR_STATUS, 32'h1);
      rd("unmapped", 8'h20, 32'h0);
      check("out", {28'h0, out}, 32'h0);
      check("hresp", {31'h0, hresp}, 32'h0);
      check("hreadyout", {31'h0, hreadyout}, 32'h1);
   endtask
   // OR path, then a thermal fault on channel 0 leaves channel 1 running
   task automatic t_or();
      wr(`ADDR_DIAG_CONTROL, 32'h0);
      drive(4'h1);
      wr(`ADDR_SWITCH, 32'h6);
      tick(2);
      check("out", {28'h0, out}, 32'h7);
      tf <= 4'h1;
      tick(2);
      check("out", {28'h0, out}, 32'h6);
      drive(4'h0);
      tf <= 4'h0;
      tick(2);
      check("out", {28'h0, out}, 32'h6);
   endtask
   task automatic t_and();
      wr(`ADDR_HW_CONTROL, 32'h1);
      drive(4'h5);
      wr(`ADDR_SWITCH, 32'h3);
      tick(2);
      check("out", {28'h0, out}, 32'h1);
      drive(4'h2);
      tick(2);
      check("out", {28'h0, out}, 32'h2);
   endtask
   // Readback of the pins, then a load-type change while channel 0 is on
   task automatic t_bank_load();
      wr(`ADDR_BANK_SWITCH, 32'h1);
      drive(4'h9);
      tick(2);
      rd("pins", `ADDR_SWITCH, 32'h9);
      wr(`ADDR_BANK_SWITCH, 32'h0);
      wr(`ADDR_LOAD_TYPE, 32'hB);
      tick(2);
      check("led", {28'h0, led}, 32'hB);
      check("out", {28'h0, out}, 32'h1);
      rd("load", `ADDR_LOAD_TYPE, 32'hB);
   endtask
   // Stand-by, then the reset command restores every default
   task automatic t_standby();
      wr(`ADDR_BANK_SWITCH, 32'h1);
      wr(`ADDR_DIAG_CONTROL, 32'h7);
      tick(2);
      check("out", {28'h0, out}, 32'h0);
      check("standby", {31'h0, standby_flag}, 32'h1);
      rd("pins", `ADDR_SWITCH, 32'h0);
      wr(`ADDR_DIAG_CONTROL, 32'h0);
      wr(`ADDR_HW_CONTROL, 32'h2);
      rd("diag", `ADDR_DIAG_CONTROL, 32'h7);
      rd("bank", `ADDR_BANK_SWITCH, 32'h0);
      rd("load", `ADDR_LOAD_TYPE, 32'h0);
      rd("hw_ctrl", `ADDR_HW_CONTROL, 32'h0);
   endtask
   // A short glitch is ignored; a long request resets config and locks writes
   task automatic t_limp();
      drive(4'h6);
      fb <= 1'b1;
      repeat (5) @(posedge hclk);
      fb <= 1'b0;
      tick(2);
      check("limp", {31'h0, limp_home}, 32'h0);
      fb <= 1'b1;
      tick(12);
      check("limp", {31'h0, limp_home}, 32'h1);
      check("out", {28'h0, out}, 32'h6);
      wr(`ADDR_SWITCH, 32'hF);
      wr(`ADDR_HW_CONTROL, 32'h1);
      tick(2);
      check("out", {28'h0, out}, 32'h6);
      rd("hw_ctrl", `ADDR_HW_CONTROL, 32'h0);
      fb <= 1'b0;
      tick(3);
      check("out", {28'h0, out}, 32'h0);
   endtask
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      hresetn = 1'b0;
      fb = 1'b0;
      pins = 4'h0;
      tf = 4'h0;
      errors = 0;
      comparisons = 0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_or();
      t_and();
      t_bank_load();
      t_standby();
      t_limp();
      report_and_stop();
   end
endmodule // channel_activation_matrix_tb
